// ---- verilog/bdm_pkg.sv ----
package bdm_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_INDIRECT = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h03;
   localparam logic [7:0] ADDR_FSP = 8'h04;
   localparam logic [7:0] ADDR_INTCTL = 8'h0b;
   localparam logic [7:0] ADDR_PFLAGS = 8'h0c;
   localparam logic [7:0] ADDR_PENABLES = 8'h0c;
   localparam logic [7:0] ADDR_GPR_LO = 8'h20;
   localparam logic [7:0] ADDR_GPR_HI = 8'h5f;
   localparam int GPR_DEPTH = 64;
   localparam int BANK_BIT = 7;
   localparam int GIE_BIT = 7;
   localparam int EE_BIT = 7;
   localparam int AD_BIT = 6;
   localparam int CM_BIT = 3;
   localparam int T1_BIT = 0;
   localparam logic [7:0] PFLAGS_MASK = 8'hc9;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [7:0] RST_FSP = 8'h00;
   localparam logic [7:0] RST_INTCTL = 8'h00;
   localparam logic [7:0] RST_PFLAGS = 8'h00;
   localparam logic [7:0] RST_PENABLES = 8'h00;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ACC = 3'b010,
      ST_ANS = 3'b100
   } bdm_host_st_t;
endpackage : bdm_pkg

// ---- verilog/bdm_if.sv ----
`timescale 1ns/1ns
interface bdm_if;
   import bdm_pkg::*;
   logic req;
   logic we;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic ack;
   modport dev (input req, we, addr, wdata, output rdata, ack);
   modport core (output req, we, addr, wdata, input rdata, ack);
endinterface : bdm_if

// ---- verilog/bdm_mem.sv ----
`timescale 1ns/1ns
module bdm_mem #(
   parameter bit HAS_ADC = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   bdm_if.dev bus,
   input wire logic eeprom_done_i,
   input wire logic conv_done_i,
   input wire logic cmp_change_i,
   input wire logic timer1_ovf_i,
   output logic [bdm_pkg::DATA_W-1:0] peripheral_flags_o,
   output logic [bdm_pkg::DATA_W-1:0] peripheral_enables_o,
   output logic [bdm_pkg::DATA_W-1:0] interrupt_control_o,
   output logic [bdm_pkg::DATA_W-1:0] core_status_o
);
   import bdm_pkg::*;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] fsp;
      logic [7:0] intctl;
      logic [7:0] pflags;
      logic [7:0] penables;
      logic [7:0] rdata;
      logic ack;
      logic [GPR_DEPTH-1:0][7:0] gpr;
   } bdm_mem_st_t;

   bdm_mem_st_t st_r;
   bdm_mem_st_t st_nxt;
   logic [8:0] eff;
   logic bank;
   logic indirect;
   logic ind_self;
   logic [5:0] gidx;
   logic hit_gpr;
   logic hit_status;
   logic hit_fsp;
   logic hit_intctl;
   logic hit_flags;
   logic hit_enables;
   logic wr_en;
   logic wr_flags;
   logic [7:0] ev_vec;
   logic [7:0] flags_nxt;
   logic [7:0] rd;

   // any operand whose low seven bits are zero names the port, in either bank
   always_comb
   begin
      indirect = (bus.addr[6:0] == ADDR_INDIRECT[6:0]);
      if (indirect)
      begin
         eff = {st_r.status[BANK_BIT], st_r.fsp};
      end
      else
      begin
         eff = bus.addr;
      end
      // bank 1 addresses here appear as 80h+; fold bit 7 into bank, keep low 7
      bank = eff[8] ^ eff[7];
      ind_self = indirect && (eff[6:0] == ADDR_INDIRECT[6:0]);
      gidx = 6'(eff[6:0] - ADDR_GPR_LO[6:0]);
   end

   // one hit at most; the port itself and unmapped holes hit nothing
   always_comb
   begin
      hit_gpr = 1'b0;
      hit_status = 1'b0;
      hit_fsp = 1'b0;
      hit_intctl = 1'b0;
      hit_flags = 1'b0;
      hit_enables = 1'b0;
      if (!ind_self)
      begin
         if (eff[6:0] >= ADDR_GPR_LO[6:0] && eff[6:0] <= ADDR_GPR_HI[6:0])
         begin
            hit_gpr = 1'b1;
         end
         else
         begin
            unique case ({1'b0, eff[6:0]})
               ADDR_STATUS: hit_status = 1'b1;
               ADDR_FSP: hit_fsp = 1'b1;
               ADDR_INTCTL: hit_intctl = 1'b1;
               ADDR_PFLAGS:
               begin
                  if (bank)
                  begin
                     hit_enables = 1'b1;
                  end
                  else
                  begin
                     hit_flags = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
      wr_en = bus.req && bus.we && !ind_self;
      wr_flags = wr_en && hit_flags;
   end

   // unmapped and unimplemented locations fall through to zero
   always_comb
   begin
      rd = 8'h00;
      if (ind_self)
         rd = 8'h00;
      else if (hit_gpr)
         rd = st_r.gpr[gidx];
      else if (hit_status)
         rd = st_r.status;
      else if (hit_fsp)
         rd = st_r.fsp;
      else if (hit_intctl)
         rd = st_r.intctl;
      else if (hit_flags)
         rd = st_r.pflags & PFLAGS_MASK;
      else if (hit_enables)
         rd = st_r.penables;
   end

   // converterless builds tie the conversion source off here
   always_comb
   begin
      ev_vec = 8'h00;
      ev_vec[EE_BIT] = eeprom_done_i;
      ev_vec[AD_BIT] = conv_done_i & HAS_ADC;
      ev_vec[CM_BIT] = cmp_change_i;
      ev_vec[T1_BIT] = timer1_ovf_i;
   end

   // flags ignore the enables; set is or-ed in after the write so no event is lost
   for (genvar i = 0; i < DATA_W; i++)
   begin : g_flag
      if (PFLAGS_MASK[i])
      begin : g_impl
         logic kept;
         assign kept = wr_flags ? bus.wdata[i] : st_r.pflags[i];
         assign flags_nxt[i] = kept | ev_vec[i];
      end
      else
      begin : g_unimpl
         assign flags_nxt[i] = 1'b0;
      end
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ack = bus.req;
      // read-during-write hands back the old contents
      if (bus.req)
         st_nxt.rdata = rd;
      if (wr_en && hit_gpr)
         st_nxt.gpr[gidx] = bus.wdata;
      if (wr_en && hit_status)
         st_nxt.status = bus.wdata;
      if (wr_en && hit_fsp)
         st_nxt.fsp = bus.wdata;
      if (wr_en && hit_intctl)
         st_nxt.intctl = bus.wdata;
      if (wr_en && hit_enables)
         st_nxt.penables = bus.wdata;
      st_nxt.pflags = flags_nxt;
      // general purpose bytes keep their contents through reset
      if (!rstn_i)
      begin
         st_nxt.status = RST_STATUS;
         st_nxt.fsp = RST_FSP;
         st_nxt.intctl = RST_INTCTL;
         st_nxt.pflags = RST_PFLAGS;
         st_nxt.penables = RST_PENABLES;
         st_nxt.rdata = 8'h00;
         st_nxt.ack = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      st_r <= st_nxt;
   end

   assign bus.rdata = st_r.rdata;
   assign bus.ack = st_r.ack;
   assign peripheral_flags_o = st_r.pflags;
   assign peripheral_enables_o = st_r.penables;
   assign interrupt_control_o = st_r.intctl;
   assign core_status_o = st_r.status;
endmodule : bdm_mem

// ---- verilog/bdm_core.sv ----
`timescale 1ns/1ns
module bdm_core (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   bdm_if.core bus,
   input wire logic cmd_valid_i,
   input wire logic cmd_we_i,
   input wire logic [bdm_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [bdm_pkg::DATA_W-1:0] cmd_wdata_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [bdm_pkg::DATA_W-1:0] rsp_data_o
);
   import bdm_pkg::*;

   typedef struct packed {
      bdm_host_st_t fsm;
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic ready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
   } bdm_core_st_t;

   bdm_core_st_t st_r;
   bdm_core_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      unique case (st_r.fsm)
         ST_IDLE:
         begin
            if (cmd_valid_i)
            begin
               st_nxt.req = 1'b1;
               st_nxt.we = cmd_we_i;
               st_nxt.addr = cmd_addr_i;
               st_nxt.wdata = cmd_wdata_i;
               st_nxt.ready = 1'b0;
               st_nxt.fsm = ST_ACC;
            end
         end
         ST_ACC:
         begin
            st_nxt.req = 1'b0;
            st_nxt.fsm = ST_ANS;
         end
         ST_ANS:
         begin
            if (bus.ack)
            begin
               st_nxt.rvalid = 1'b1;
               st_nxt.rdata = bus.rdata;
               st_nxt.ready = 1'b1;
               st_nxt.fsm = ST_IDLE;
            end
         end
         default: st_nxt.fsm = ST_IDLE;
      endcase
      if (!rstn_i)
      begin
         st_nxt.fsm = ST_IDLE;
         st_nxt.req = 1'b0;
         st_nxt.we = 1'b0;
         st_nxt.addr = '0;
         st_nxt.wdata = '0;
         st_nxt.ready = 1'b1;
         st_nxt.rvalid = 1'b0;
         st_nxt.rdata = '0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      st_r <= st_nxt;
   end

   assign bus.req = st_r.req;
   assign bus.we = st_r.we;
   assign bus.addr = st_r.addr;
   assign bus.wdata = st_r.wdata;
   assign cmd_ready_o = st_r.ready;
   assign rsp_valid_o = st_r.rvalid;
   assign rsp_data_o = st_r.rdata;
endmodule : bdm_core

// ---- tb/bdm_asserts.sv ----
`timescale 1ns/1ns
module bdm_asserts (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic req,
   input wire logic we,
   input wire logic [bdm_pkg::ADDR_W-1:0] addr,
   input wire logic [bdm_pkg::DATA_W-1:0] wdata,
   input wire logic [bdm_pkg::DATA_W-1:0] rdata,
   input wire logic ack
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // back-to-back core accesses sit exactly 3 cycles apart
   sequence s_self;
      req && we && addr[6:0] == 7'h04 && wdata[6:0] == 7'h00;
   endsequence
   sequence s_nop_wr;
      s_self ##3 req && we && addr[6:0] == 7'h00 ##3 req && !we && addr[6:0] == 7'h04;
   endsequence
   a_ack_after_req: assert property (req |=> ack && !req)
      else $error("no ack after access");
   a_no_stray_ack: assert property (!req |=> !ack)
      else $error("ack without access");
   a_flags_unused: assert property (req && !we && addr == 9'h00c
      |=> rdata[5:4] == 2'b00 && rdata[2:1] == 2'b00) else $error("unused flag bit set");
   a_unmapped_zero: assert property (req && !we && addr[6:5] == 2'b11
      |=> rdata == 8'h00) else $error("unmapped read not zero");
   a_gpr_shared: assert property (req && we && addr[6:0] inside {[7'h20:7'h5f]}
      ##3 req && !we && addr[6:0] == $past(addr[6:0], 3) |=> rdata == $past(wdata, 4))
      else $error("shared byte lost");
   a_ind_redirect: assert property (req && we && addr[6:0] == 7'h04
      && wdata[6:0] inside {[7'h20:7'h5f]} ##3 req && we && addr[6:0] == 7'h00
      ##3 req && !we && addr[6:0] == $past(wdata[6:0], 6) |=> rdata == $past(wdata, 4))
      else $error("indirect write misplaced");
   a_self_nop: assert property (s_nop_wr |=> rdata == $past(wdata, 7))
      else $error("self write stored");
   a_self_zero: assert property (s_nop_wr ##3 req && !we && addr[6:0] == 7'h00
      |=> rdata == 8'h00) else $error("self read not zero");
endmodule : bdm_asserts

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
   import bdm_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cv = 1'b0;
   logic cw = 1'b0;
   logic [ADDR_W-1:0] ca = '0;
   logic [DATA_W-1:0] cd = '0;
   logic [3:0] ev = 4'h0;
   logic rdy, rv;
   logic [DATA_W-1:0] rd, pf;
   logic [DATA_W-1:0] pe, ic, cs;
   logic [8:0] expq[$];
   int err_count = 0;
   int checked = 0;
   bdm_if bus_if();
   bdm_mem bdm_mem_inst (.ref_clk_i(clk), .rstn_i(rstn), .bus(bus_if.dev),
      .eeprom_done_i(ev[3]), .conv_done_i(ev[2]), .cmp_change_i(ev[1]),
      .timer1_ovf_i(ev[0]), .peripheral_flags_o(pf), .peripheral_enables_o(pe),
      .interrupt_control_o(ic), .core_status_o(cs));
   bdm_core bdm_core_inst (.ref_clk_i(clk), .rstn_i(rstn), .bus(bus_if.core),
      .cmd_valid_i(cv), .cmd_we_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd),
      .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rd));
   bdm_asserts bdm_asserts_inst (.ref_clk_i(clk), .rstn_i(rstn), .req(bus_if.req),
      .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .ack(bus_if.ack));
   initial forever #50 clk = ~clk;
   function automatic logic [7:0] efl(input logic [3:0] f);
      return {f[3], f[2], 2'b00, f[1], 2'b00, f[0]};
   endfunction : efl
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8
   // returns at the edge ready comes back, so the next call runs back to back
   task automatic cmd(input logic w, input logic [8:0] a, input logic [7:0] d,
      input logic [8:0] e);
      cv <= 1'b1;
      cw <= w;
      ca <= a;
      cd <= d;
      @(posedge clk);
      cmp8({7'h00, rdy}, 8'h01);
      expq.push_back(e);
      cv <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : cmd
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   always @(posedge clk)
   begin : rsp_mon
      logic [8:0] e;
      if (rv === 1'b1 && expq.size() == 0)
         cmp8(8'h01, 8'h00);
      else if (rv === 1'b1)
      begin
         e = expq.pop_front();
         if (e[8])
            cmp8(rd, e[7:0]);
      end
   end
   initial
   begin
      logic [8:0] a;
      logic [7:0] d, p, x;
      logic [3:0] f;
      x = 8'($urandom(32'ha8c8));
      x = 8'h00;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      cmd(1'b0, 9'h003, 8'h00, {1'b1, RST_STATUS});
      cmd(1'b0, 9'h00b, 8'h00, 9'h100);
      cmd(1'b0, 9'h00c, 8'h00, 9'h100);
      cmd(1'b0, 9'h060, 8'h00, 9'h100);
      repeat (4)
      begin
         f = 4'($urandom);
         ev <= f;
         @(posedge clk);
         ev <= 4'h0;
         @(posedge clk);
         x = x | efl(f);
         cmp8(pf, x);
      end
      cmd(1'b1, 9'h00c, 8'hff, 9'h000);
      cmd(1'b0, 9'h00c, 8'h00, {1'b1, PFLAGS_MASK});
      f = 4'($urandom) | 4'h1;
      fork
         cmd(1'b1, 9'h00c, 8'h00, 9'h000);
         begin
            @(posedge clk);
            ev <= f;
            @(posedge clk);
            ev <= 4'h0;
         end
      join
      cmd(1'b0, 9'h00c, 8'h00, {1'b1, efl(f)});
      cmd(1'b1, 9'h00c, 8'h00, 9'h000);
      cmp8(pf, 8'h00);
      cmd(1'b1, 9'h08c, 8'hc9, 9'h000); // flags cleared before enabling
      cmp8(pe, 8'hc9);
      cmd(1'b1, 9'h08b, 8'h80, 9'h000);
      cmp8(ic, 8'h80);
      cmd(1'b0, 9'h00b, 8'h00, 9'h180);
      f = 4'($urandom);
      ev <= f;
      @(posedge clk);
      ev <= 4'h0;
      @(posedge clk);
      cmp8(pf, efl(f));
      repeat (6)
      begin
         a = {2'($urandom), 7'h20 + 7'($urandom % 64)};
         d = 8'($urandom);
         cmd(1'b1, a, d, 9'h000);
         cmd(1'b0, {2'($urandom), a[6:0]}, 8'h00, {1'b1, d});
      end
      p = {1'($urandom), 7'h20 + 7'($urandom % 64)};
      cmd(1'b1, 9'h004, p, 9'h000);
      cmd(1'b1, 9'h000, ~d, 9'h000);
      cmd(1'b0, {2'b00, p[6:0]}, 8'h00, {1'b1, ~d});
      cmd(1'b0, 9'h080, 8'h00, {1'b1, ~d});
      cmd(1'b1, 9'h004, 8'h00, 9'h000);
      cmd(1'b1, 9'h000, d, 9'h000);
      cmd(1'b0, 9'h004, 8'h00, 9'h100);
      cmd(1'b0, 9'h000, 8'h00, 9'h100);
      repeat (4) @(posedge clk);
      cmp8(cs, RST_STATUS);
      cmp8(8'(expq.size()), 8'h00);
      conclude();
   end
endmodule : tb
